// ==== rtl/csp_counter.sv ====
// Counter channel: accumulator, load, strobe capture, rate, preset output
`timescale 1ns/10ps
module csp_counter #(
  parameter int ACC_W    = 32,
  parameter int NSTB     = 2,
  parameter int MS_P     = csp_pkg::MS_CYC,
  parameter int LONG_P   = csp_pkg::LONG_FILT_CYC,
  parameter int COINC_P  = csp_pkg::COINC_CYC
) (
  input  wire logic                  clk,
  input  wire logic                  sys_rst,
  input  wire logic                  ce,
  input  wire csp_pkg::csp_apb_req_t apb_req,
  output csp_pkg::csp_apb_rsp_t      apb_rsp,
  input  wire logic                  count_in,
  input  wire logic                  preload_in,
  input  wire logic [NSTB-1:0]       strobe_in,
  output logic                       out_sw
);
  import csp_pkg::*;

  localparam int MSW = $clog2(MS_P);
  localparam int CW  = $clog2(COINC_P + 1);

  if (ACC_W < 16 || ACC_W > 32 || NSTB < 1 || NSTB > 4 ||
      MS_P < 2 || COINC_P < 2) begin : g_bad
    $error("csp_counter: unsupported parameter values");
  end

  localparam logic [ACC_W-1:0] ACC_MAX = {1'b0, {(ACC_W-1){1'b1}}};
  localparam logic [ACC_W-1:0] ACC_MIN = {1'b1, {(ACC_W-1){1'b0}}};

  typedef struct packed {
    logic [ACC_W-1:0]            acc;
    logic [ACC_W-1:0]            pre;
    logic [ACC_W-1:0]            on_p;
    logic [ACC_W-1:0]            off_p;
    logic [NSTB-1:0][ACC_W-1:0]  cap;
    logic [7:0]                  ctrl;
    logic [15:0]                 tb;
    logic [15:0]                 tb_cnt;
    logic [MSW-1:0]              ms_cnt;
    logic [15:0]                 tally;
    logic [15:0]                 rate;
    logic                        pl_flag;
    logic [NSTB-1:0]             cap_flag;
    logic                        err;
    logic                        cnt_prev;
    logic                        pl_prev;
    logic [NSTB-1:0]             stb_prev;
    logic [CW-1:0]               pl_age;
    logic [NSTB-1:0][CW-1:0]     stb_age;
    logic                        out;
    csp_apb_rsp_t                rsp;
  } csp_st_t;

  csp_st_t q, n;

  // ----------------------------------------------------------------
  // Address decode, shared by the read mux and the error answer
  // ----------------------------------------------------------------
  function automatic logic map_ok(input logic [7:0] a);
    map_ok = (a <= A_OFF && a[1:0] == 2'b00) ||
             (a >= A_CAP0 && a < A_CAP0 + 8'(4 * NSTB) &&
              a[1:0] == 2'b00);
  endfunction : map_ok

  // ----------------------------------------------------------------
  // Input filters; strobes never see the long filter
  // ----------------------------------------------------------------
  logic cf;
  logic pf;

  csp_filter #(.LONG_CYC(LONG_P)) u_cnt_flt (
    .clk      (clk),
    .sys_rst  (sys_rst),
    .ce       (ce),
    .din      (count_in),
    .long_sel (q.ctrl[CB_CLONG]),
    .dout     (cf)
  );

  csp_filter #(.LONG_CYC(LONG_P)) u_pl_flt (
    .clk      (clk),
    .sys_rst  (sys_rst),
    .ce       (ce),
    .din      (preload_in),
    .long_sel (q.ctrl[CB_PLONG]),
    .dout     (pf)
  );

  // ----------------------------------------------------------------
  // Edge events
  // ----------------------------------------------------------------
  logic            cnt_ev;
  logic            pl_ev;
  logic            pl_recent;
  logic [NSTB-1:0] stb_ev;
  logic [NSTB-1:0] stb_recent;
  logic            acc_in;
  logic            wr_go;
  logic            win_end;

  assign cnt_ev    = cf && !q.cnt_prev;
  assign pl_ev     = pf && !q.pl_prev;
  assign pl_recent = q.pl_age < CW'(COINC_P);
  assign acc_in    = apb_req.psel && apb_req.penable;
  assign wr_go     = acc_in && apb_req.pwrite && q.rsp.pready;
  assign win_end   = q.ms_cnt == MSW'(MS_P - 1) &&
                     q.tb_cnt >= q.tb - 16'h0001; // TB write clears tb_cnt (unless ms_cnt wraps then) but not tally, so the next window keeps earlier counts

  // Strobe edge polarity per input, straight from the raw pin
  always_comb begin
    for (int i = 0; i < NSTB; i++) begin
      stb_ev[i] = q.ctrl[CB_SNEG + i] ?
                  (!strobe_in[i] && q.stb_prev[i]) :
                  (strobe_in[i] && !q.stb_prev[i]);
      stb_recent[i] = q.stb_age[i] < CW'(COINC_P);
    end
  end

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    n          = q;
    n.cnt_prev = cf;
    n.pl_prev  = pf;
    n.stb_prev = strobe_in;

    // APB: ready one cycle into the access phase, write at ready edge
    n.rsp.pready = acc_in && !q.rsp.pready;
    if (acc_in && !q.rsp.pready) begin
      n.rsp.prdata  = 32'h0000_0000;
      n.rsp.pslverr = !map_ok(apb_req.paddr) ||
                      (apb_req.pwrite && apb_req.paddr == A_TB &&
                       apb_req.pwdata[15:0] == 16'h0000);
      if (!apb_req.pwrite && map_ok(apb_req.paddr)) begin
        unique case (apb_req.paddr)
          A_CTRL:  n.rsp.prdata = {24'h00_0000, q.ctrl};
          A_TB:    n.rsp.prdata = {16'h0000, q.tb};
          A_PRE:   n.rsp.prdata = 32'($signed(q.pre));
          A_ACC:   n.rsp.prdata = 32'($signed(q.acc));
          A_RATE:  n.rsp.prdata = 32'($signed(q.rate));
          A_FLAGS: n.rsp.prdata = 32'({q.cap_flag, 2'b00, q.err,
                                       q.pl_flag});
          A_ON:    n.rsp.prdata = 32'($signed(q.on_p));
          A_OFF:   n.rsp.prdata = 32'($signed(q.off_p));
          default: n.rsp.prdata =
                   32'($signed(q.cap[apb_req.paddr[3:2]]));
        endcase
      end
    end else begin
      n.rsp.pslverr = 1'b0;
    end

    // Register writes; clears come first so that events set after
    if (wr_go) begin
      unique case (apb_req.paddr)
        A_CTRL: n.ctrl = apb_req.pwdata[7:0];
        A_TB: begin
          if (apb_req.pwdata[15:0] == 16'h0000) begin
            n.err = 1'b1;
          end else begin
            n.tb     = apb_req.pwdata[15:0];
            n.tb_cnt = 16'h0000;
          end
        end
        A_PRE: n.pre   = apb_req.pwdata[ACC_W-1:0];
        A_ACC: n.acc   = apb_req.pwdata[ACC_W-1:0];
        A_ON:  n.on_p  = apb_req.pwdata[ACC_W-1:0];
        A_OFF: n.off_p = apb_req.pwdata[ACC_W-1:0];
        A_FLAGS: begin
          n.pl_flag  = q.pl_flag & ~apb_req.pwdata[FB_PL];
          n.err      = q.err & ~apb_req.pwdata[FB_ERR];
          n.cap_flag = q.cap_flag & ~apb_req.pwdata[FB_CAP +: NSTB];
        end
        default: ;
      endcase
    end

    // Accumulator: load beats software write beats count
    if (pl_ev) begin
      n.acc     = q.pre;
      n.pl_flag = 1'b1;
    end else if (cnt_ev && !(wr_go && apb_req.paddr == A_ACC)) begin
      if (q.ctrl[CB_DOWN]) begin
        if (!(q.ctrl[CB_SINGLE] && q.acc == ACC_MIN)) begin
          n.acc = q.acc - ACC_W'(1);
        end
      end else begin
        if (!(q.ctrl[CB_SINGLE] && q.acc == ACC_MAX)) begin
          n.acc = q.acc + ACC_W'(1);
        end
      end
    end

    // Rate window: ms prescaler, then timebase count
    if (cnt_ev) begin
      n.tally = q.ctrl[CB_DOWN] ? q.tally - 16'h0001
                                : q.tally + 16'h0001;
    end
    n.ms_cnt = (q.ms_cnt == MSW'(MS_P - 1)) ? '0 : q.ms_cnt + MSW'(1);
    if (q.ms_cnt == MSW'(MS_P - 1)) begin
      if (win_end) begin
        n.rate   = n.tally;
        n.tally  = 16'h0000;
        n.tb_cnt = 16'h0000;
      end else begin
        n.tb_cnt = q.tb_cnt + 16'h0001;
      end
    end

    // Coincidence timers saturate at the window length
    n.pl_age = pl_ev ? '0 : (pl_recent ? q.pl_age + CW'(1) : q.pl_age);
    for (int i = 0; i < NSTB; i++) begin
      n.stb_age[i] = stb_ev[i] ? '0 :
                     (stb_recent[i] ? q.stb_age[i] + CW'(1)
                                    : q.stb_age[i]);
      // Each strobe owns its register; no cross-coupling
      if (stb_ev[i]) begin
        n.cap[i]      = (pl_ev || pl_recent) ? q.pre : q.acc;
        n.cap_flag[i] = 1'b1;
      end else if (pl_ev && stb_recent[i]) begin
        n.cap[i] = q.pre;
      end
    end

    // Output band: inclusive at both presets when on_p <= off_p, exclusive at both otherwise
    if ($signed(q.on_p) <= $signed(q.off_p)) begin
      n.out = $signed(q.acc) >= $signed(q.on_p) &&
              $signed(q.acc) <= $signed(q.off_p);
    end else begin
      n.out = $signed(q.acc) < $signed(q.off_p) ||
              $signed(q.acc) > $signed(q.on_p);
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      q         <= '0;
      q.ctrl    <= CTRL_RST;
      q.tb      <= TB_RST;
      q.pl_age  <= CW'(COINC_P);
      q.stb_age <= {NSTB{CW'(COINC_P)}};
    end else if (ce) begin
      q <= n;
    end
  end

  // Output follows the accumulator by one edge, far inside 1 ms
  assign out_sw  = q.out;
  assign apb_rsp = q.rsp;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  a_load_value: assert property (
    ce && pl_ev |=> q.acc == $past(q.pre) && q.pl_flag)
    else $error("load did not force the accumulator");

  a_cap_latch: assert property (
    ce && stb_ev[0] && !pl_ev && !pl_recent
    |=> q.cap[0] == $past(q.acc) && q.cap_flag[0])
    else $error("strobe did not capture the count");

  a_cap_hold: assert property (
    ce && !stb_ev[0] && !pl_ev |=> $stable(q.cap[0]))
    else $error("capture changed without a strobe");

  a_coinc_load: assert property (
    ce && stb_ev[0] && pl_recent |=> q.cap[0] == $past(q.pre))
    else $error("strobe near a load missed the load value");

  a_set_wins: assert property (
    ce && stb_ev[0] && wr_go && apb_req.paddr == A_FLAGS
    |=> q.cap_flag[0])
    else $error("flag clear swallowed a strobe event");

  a_rate_still: assert property (
    ce && !(q.ms_cnt == MSW'(MS_P - 1) && win_end) |=> $stable(q.rate))
    else $error("rate changed inside a window");

  a_tb_reject: assert property (
    ce && wr_go && apb_req.paddr == A_TB &&
    apb_req.pwdata[15:0] == 16'h0000
    |=> q.tb == $past(q.tb) && q.err)
    else $error("zero timebase was accepted");

  a_single_stop: assert property (
    ce && q.ctrl[CB_SINGLE] && !q.ctrl[CB_DOWN] && q.acc == ACC_MAX &&
    !pl_ev && !wr_go |=> q.acc == ACC_MAX)
    else $error("single shot passed its upper limit");

  a_out_follow: assert property (
    ce && !pl_ev && !wr_go ##1 ce && !pl_ev && !wr_go ##1 1'b1
    |-> q.out == (($signed($past(q.acc)) >= $signed($past(q.on_p)) &&
         $signed($past(q.acc)) <= $signed($past(q.off_p))) ||
        ($signed($past(q.on_p)) > $signed($past(q.off_p)) &&
         ($signed($past(q.acc)) < $signed($past(q.off_p)) ||
          $signed($past(q.acc)) > $signed($past(q.on_p))))))
    else $error("output does not reflect the preset band");

  a_apb_ready: assert property (
    ce && acc_in && !q.rsp.pready |=> q.rsp.pready)
    else $error("access phase got no ready");

  c_load:  cover property (ce && pl_ev);
  c_win:   cover property (ce && win_end && q.ms_cnt == MSW'(MS_P - 1));
  c_coinc: cover property (ce && stb_ev[0] && pl_recent);

endmodule : csp_counter

// ==== rtl/csp_filter.sv ====
// Input filter: one-cycle short path or long stability filter
`timescale 1ns/10ps
module csp_filter #(
  parameter int LONG_CYC = csp_pkg::LONG_FILT_CYC
) (
  input  wire logic clk,
  input  wire logic sys_rst,
  input  wire logic ce,
  input  wire logic din,
  input  wire logic long_sel,
  output logic      dout
);
  import csp_pkg::*;

  localparam int CW = $clog2(LONG_CYC + 1);

  if (LONG_CYC < 2) begin : g_bad
    $error("csp_filter: LONG_CYC must be at least 2");
  end

  typedef struct packed {
    logic          lvl;
    logic [CW-1:0] cnt;
  } csp_flt_st_t;

  csp_flt_st_t q, n;

  // ----------------------------------------------------------------
  // Level follows input at once, or after LONG_CYC stable cycles
  // ----------------------------------------------------------------
  always_comb begin
    n = q;
    if (din == q.lvl) begin
      n.cnt = '0;
    end else if (!long_sel || q.cnt == CW'(LONG_CYC - 1)) begin
      n.lvl = din;
      n.cnt = '0;
    end else begin
      n.cnt = q.cnt + CW'(1);
    end
  end

  // State register; clock enable freezes it
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      q <= '0;
    end else if (ce) begin
      q <= n;
    end
  end

  assign dout = q.lvl;

endmodule : csp_filter

// ==== rtl/csp_pkg.sv ====
// Shared constants, bus carriers and behaviour summary of the counter channel
// What this block does
// - Rate counts events over a timebase of 1 to 65535 ms.
// - Rate result refreshes once at each timebase end, not continuously.
// - Capture registers latch the accumulator on the selected strobe edge.
// - Rising count edge steps accumulator up or down by one.
// - Count input filter is short or 12.5 ms long; short by default.
// - Load value, zero after reset, forced into accumulator on load.
// - Load reacts to rising edges; short or long filter, short default.
// - Load during counting lands within one count and sets a flag.
// - Each strobe triggers on its rising or its falling edge.
// - Strobes use neither filter; their edges come from the raw pin.
// - Simultaneous strobes each capture correctly into their own register.
// - Strobe stores the count in its capture register and sets a flag.
// - Captured value holds until the next active strobe on that input, or a load within 0.5 ms after it.
// - Strobe and load within 0.5 ms both take the load value.
// - Output switches when the count reaches its preset values.
// - Count event to output change within 1 ms plus filter time.
// - A zero timebase (bits 15:0) is refused with an error; other values are taken as written.
// - Rate is 16-bit signed, positive up, negative down.
// - Continuous mode wraps past a limit to the opposite limit.
// - Single-shot mode stops at a limit; opposite counts back off.
// - Output shows count between presets; polarity by preset order.
package csp_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ       = 20;
  localparam int MS_US         = 1000;
  localparam int MS_CYC        = MS_US * CLK_MHZ;
  localparam int LONG_FILT_US  = 12500;
  localparam int LONG_FILT_CYC = LONG_FILT_US * CLK_MHZ;
  localparam int COINC_US      = 500;
  localparam int COINC_CYC     = COINC_US * CLK_MHZ;

  // ----------------------------------------------------------------
  // Register map (byte addresses) and fields
  // ----------------------------------------------------------------
  localparam logic [7:0] A_CTRL  = 8'h00;
  localparam logic [7:0] A_TB    = 8'h04;
  localparam logic [7:0] A_PRE   = 8'h08;
  localparam logic [7:0] A_ACC   = 8'h0c;
  localparam logic [7:0] A_RATE  = 8'h10;
  localparam logic [7:0] A_FLAGS = 8'h14;
  localparam logic [7:0] A_ON    = 8'h18;
  localparam logic [7:0] A_OFF   = 8'h1c;
  localparam logic [7:0] A_CAP0  = 8'h20;

  localparam int CB_DOWN   = 0;
  localparam int CB_SINGLE = 1;
  localparam int CB_CLONG  = 2;
  localparam int CB_PLONG  = 3;
  localparam int CB_SNEG   = 4;
  localparam int FB_PL     = 0;
  localparam int FB_ERR    = 1;
  localparam int FB_CAP    = 4;

  localparam logic [7:0]  CTRL_RST = 8'h00;
  localparam logic [15:0] TB_RST   = 16'h0001;

  // ----------------------------------------------------------------
  // APB carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } csp_apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } csp_apb_rsp_t;

endpackage : csp_pkg

// ==== tb/csp_counter_tb.sv ====
// Self-checking bench for the counter channel
`timescale 1ns/10ps
module csp_counter_tb;
  import csp_pkg::*;

  // ----------------------------------------------------------------
  // Signals and instances
  // ----------------------------------------------------------------
  logic         clk        = 1'b0;
  logic         sys_rst;
  logic         ce_in;
  logic         count_in;
  logic         preload_in;
  logic [1:0]   strobe_in;
  logic         out_sw;
  csp_apb_req_t apb_req;
  csp_apb_rsp_t apb_rsp;
  int           n_errors   = 0;
  int           compares   = 0;
  logic [31:0]  q;
  logic         e;

  // Short counts keep the run brief; expectations use these values
  csp_counter #(.MS_P(4), .LONG_P(8), .COINC_P(6)) uut (
    .clk(clk), .sys_rst(sys_rst), .ce(ce_in), .apb_req(apb_req),
    .apb_rsp(apb_rsp), .count_in(count_in), .preload_in(preload_in),
    .strobe_in(strobe_in), .out_sw(out_sw)
  );

  csp_host_model host (.clk(clk), .apb_req(apb_req), .apb_rsp(apb_rsp));

  // 20 MHz clock
  always #25 clk = ~clk;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string msg);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: %s got %h want %h", $time, msg, got,
               exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    host.xf(1'b1, a, d, q, e);
  endtask : wr

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    host.xf(1'b0, a, 32'h0, q, e);
    chk(q, exp, "read data");
  endtask : rdc

  // Count input needs a low cycle between pulses for edge detection
  task automatic pulse(input int n);
    repeat (n) begin
      @(posedge clk) count_in <= 1'b1;
      @(posedge clk) count_in <= 1'b0;
    end
    repeat (3) @(posedge clk);
  endtask : pulse

  task automatic out_at(input logic [31:0] acc, input logic exp);
    wr(A_ACC, acc);
    repeat (4) @(posedge clk);
    chk({31'h0, out_sw}, {31'h0, exp}, "output level");
  endtask : out_at

  task automatic rate_run(input logic [15:0] exp);
    fork
      pulse(20);
      begin
        repeat (28) @(posedge clk);
        host.xf(1'b0, A_RATE, 32'h0, q, e);
        chk({16'h0, q[15:0]}, {16'h0, exp}, "rate");
      end
    join
  endtask : rate_run

  task automatic end_sim();
    $display("compares %0d n_errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : end_sim

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    rdc(A_CTRL, 32'h0);
    rdc(A_TB, 32'h1);
    rdc(A_PRE, 32'h0);
    rdc(A_RATE, 32'h0);
    rdc(A_FLAGS, 32'h0);
    host.xf(1'b0, 8'h30, 32'h0, q, e);
    chk({31'h0, e}, 32'h1, "unmapped address");
    $display("test reset done");
  endtask : t_reset

  task automatic t_count();
    wr(A_ACC, 32'h0);
    pulse(3);
    rdc(A_ACC, 32'h3);
    wr(A_CTRL, 32'h1);
    pulse(2);
    rdc(A_ACC, 32'h1);
    wr(A_CTRL, 32'h4);
    wr(A_ACC, 32'h0);
    // Long filter: a 4-cycle pulse is swallowed, a 12-cycle one counts
    @(posedge clk) count_in <= 1'b1;
    repeat (4) @(posedge clk);
    count_in <= 1'b0;
    repeat (12) @(posedge clk);
    rdc(A_ACC, 32'h0);
    @(posedge clk) count_in <= 1'b1;
    repeat (12) @(posedge clk);
    count_in <= 1'b0;
    repeat (12) @(posedge clk);
    rdc(A_ACC, 32'h1);
    $display("test count done");
  endtask : t_count

  task automatic t_load();
    host.cfg(32'h0, 32'h1, 32'h64, 32'h0, 32'h0);
    host.clr(32'hffffffff);
    @(posedge clk) preload_in <= 1'b1;
    pulse(2);
    preload_in <= 1'b0;
    rdc(A_ACC, 32'h66);
    rdc(A_FLAGS, 32'h1);
    host.clr(32'h1);
    rdc(A_FLAGS, 32'h0);
    // Long load filter: a 4-cycle pulse is swallowed, a 12-cycle one loads
    wr(A_CTRL, 32'h8);
    wr(A_ACC, 32'h0);
    @(posedge clk) preload_in <= 1'b1;
    repeat (4) @(posedge clk);
    preload_in <= 1'b0;
    repeat (12) @(posedge clk);
    rdc(A_ACC, 32'h0);
    @(posedge clk) preload_in <= 1'b1;
    repeat (12) @(posedge clk);
    preload_in <= 1'b0;
    repeat (12) @(posedge clk);
    rdc(A_ACC, 32'h64);
    wr(A_CTRL, 32'h0);
    $display("test load done");
  endtask : t_load

  task automatic t_strobe();
    wr(A_ACC, 32'h14);
    host.clr(32'hffffffff);
    @(posedge clk) strobe_in <= 2'h3;
    repeat (3) @(posedge clk);
    rdc(A_CAP0, 32'h14);
    rdc(A_CAP0 + 8'h04, 32'h14);
    rdc(A_FLAGS, 32'h30);
    wr(A_ACC, 32'h1e);
    @(posedge clk) strobe_in <= 2'h0;
    repeat (3) @(posedge clk);
    rdc(A_CAP0, 32'h14);
    wr(A_CTRL, 32'h20);
    @(posedge clk) strobe_in <= 2'h3;
    repeat (3) @(posedge clk);
    rdc(A_CAP0, 32'h1e);
    rdc(A_CAP0 + 8'h04, 32'h14);
    @(posedge clk) strobe_in <= 2'h0;
    repeat (3) @(posedge clk);
    rdc(A_CAP0 + 8'h04, 32'h1e);
    // Strobe then load one cycle apart both take the load value
    wr(A_ACC, 32'h32);
    @(posedge clk) strobe_in <= 2'h1;
    @(posedge clk) preload_in <= 1'b1;
    repeat (10) @(posedge clk);
    preload_in <= 1'b0;
    rdc(A_CAP0, 32'h64);
    rdc(A_ACC, 32'h64);
    // Load, then a count, then a strobe: capture still takes the load
    @(posedge clk) strobe_in <= 2'h0;
    wr(A_ACC, 32'h5);
    @(posedge clk) strobe_in <= 2'h1;
    @(posedge clk) strobe_in <= 2'h0;
    rdc(A_CAP0, 32'h5);
    @(posedge clk) preload_in <= 1'b1;
    @(posedge clk) count_in <= 1'b1;
    @(posedge clk) count_in <= 1'b0;
    @(posedge clk) strobe_in <= 2'h1;
    repeat (2) @(posedge clk);
    preload_in <= 1'b0;
    rdc(A_CAP0, 32'h64);
    rdc(A_ACC, 32'h65);
    // A strobe in the very cycle of its flag clear keeps the flag
    @(posedge clk) strobe_in <= 2'h0;
    fork
      host.clr(32'h10);
      begin
        repeat (3) @(posedge clk);
        strobe_in <= 2'h1;
      end
    join
    rdc(A_FLAGS, 32'h31);
    $display("test strobe done");
  endtask : t_strobe

  task automatic t_rate();
    wr(A_CTRL, 32'h0);
    wr(A_TB, 32'h2);
    rate_run(16'h0004);
    wr(A_CTRL, 32'h1);
    rate_run(16'hfffc);
    host.clr(32'hffffffff);
    host.xf(1'b1, A_TB, 32'h0, q, e);
    chk({31'h0, e}, 32'h1, "zero timebase");
    rdc(A_TB, 32'h2);
    rdc(A_FLAGS, 32'h2);
    $display("test rate done");
  endtask : t_rate

  task automatic t_out();
    host.cfg(32'h0, 32'h2, 32'h0, 32'h5, 32'ha);
    out_at(32'h4, 1'b0);
    out_at(32'h5, 1'b1);
    out_at(32'ha, 1'b1);
    out_at(32'hb, 1'b0);
    out_at(32'h4, 1'b0);
    // Count edge to output change within three cycles
    @(posedge clk) count_in <= 1'b1;
    @(posedge clk) count_in <= 1'b0;
    repeat (2) @(posedge clk);
    #1 chk({31'h0, out_sw}, 32'h1, "output delay");
    host.cfg(32'h0, 32'h2, 32'h0, 32'ha, 32'h5);
    out_at(32'h4, 1'b1);
    out_at(32'h7, 1'b0);
    out_at(32'hb, 1'b1);
    $display("test output done");
  endtask : t_out

  task automatic t_wrap();
    wr(A_CTRL, 32'h0);
    wr(A_ACC, 32'h7fffffff);
    pulse(1);
    rdc(A_ACC, 32'h80000000);
    wr(A_CTRL, 32'h2);
    wr(A_ACC, 32'h7fffffff);
    pulse(2);
    rdc(A_ACC, 32'h7fffffff);
    wr(A_CTRL, 32'h3);
    pulse(1);
    rdc(A_ACC, 32'h7ffffffe);
    $display("test wrap done");
  endtask : t_wrap

  // Clock enable low freezes the channel; counts resume once it is high
  task automatic t_freeze();
    wr(A_CTRL, 32'h0);
    wr(A_ACC, 32'h0);
    @(posedge clk) ce_in <= 1'b0;
    pulse(2);
    @(posedge clk) ce_in <= 1'b1;
    repeat (2) @(posedge clk);
    rdc(A_ACC, 32'h0);
    pulse(1);
    rdc(A_ACC, 32'h1);
    $display("test freeze done");
  endtask : t_freeze

  // ----------------------------------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    sys_rst    <= 1'b1;
    ce_in      <= 1'b1;
    count_in   <= 1'b0;
    preload_in <= 1'b0;
    strobe_in  <= 2'h0;
    repeat (4) @(posedge clk);
    sys_rst <= 1'b0;
    t_reset();
    t_count();
    t_load();
    t_strobe();
    t_rate();
    t_out();
    t_wrap();
    t_freeze();
    end_sim();
  end

  // Whole run is well under a thousand cycles; far beyond that means a hang
  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    end_sim();
  end

endmodule : csp_counter_tb

// ==== tb/csp_host_model.sv ====
// Controller-side model that reaches the counter channel over APB
`timescale 1ns/10ps
module csp_host_model
  import csp_pkg::*;
(
  input  wire logic                  clk,
  output csp_pkg::csp_apb_req_t      apb_req,
  input  wire csp_pkg::csp_apb_rsp_t apb_rsp
);

  // ----------------------------------------------------------------
  // Bus idle at time zero
  // ----------------------------------------------------------------
  initial begin
    apb_req = '0;
  end

  // ----------------------------------------------------------------
  // Transfers
  // ----------------------------------------------------------------
  // One transfer; waits an edge first so back-to-back calls never
  // assign apb_req twice in one time step
  task automatic xf(input logic w, input logic [7:0] a,
                    input logic [31:0] d, output logic [31:0] q,
                    output logic e);
    @(posedge clk);
    apb_req <= '{1'b1, 1'b0, w, a, d};
    @(posedge clk);
    apb_req.penable <= 1'b1;
    // The slave sets the pace; only the bench watchdog ends a hang
    do @(posedge clk); while (apb_rsp.pready !== 1'b1);
    q = apb_rsp.prdata;
    e = apb_rsp.pslverr;
    apb_req <= '0;
  endtask : xf

  // Acknowledged flags are written back as ones to clear them
  task automatic clr(input logic [31:0] mask);
    logic [31:0] q;
    logic        e;
    xf(1'b1, A_FLAGS, mask, q, e);
  endtask : clr

  // The whole configuration goes down as five separate writes, control first and off preset last
  task automatic cfg(input logic [31:0] ctrl, input logic [31:0] tb,
                     input logic [31:0] pre, input logic [31:0] on,
                     input logic [31:0] off);
    logic [31:0] q;
    logic        e;
    xf(1'b1, A_CTRL, ctrl, q, e);
    xf(1'b1, A_TB, tb, q, e);
    xf(1'b1, A_PRE, pre, q, e);
    xf(1'b1, A_ON, on, q, e);
    xf(1'b1, A_OFF, off, q, e);
  endtask : cfg

endmodule : csp_host_model
